//--- common/gmx_params.svh
`ifndef GMX_PARAMS_SVH
`define GMX_PARAMS_SVH

// Pin function select codes
`define GMX_FN_ALT 9'h000
`define GMX_FN_GPIO 9'h001
`define GMX_FN_DSP 9'h002
`define GMX_FN_INTERRUPT_REQUEST_ONE 9'h003
`define GMX_FN_INTERRUPT_REQUEST_TWO 9'h004
`define GMX_FN_FLL_CLK 9'h010
`define GMX_FN_FLL_LOCK 9'h018
`define GMX_FN_DIVIDED_SYSTEM_CLOCK_OUT 9'h040
`define GMX_FN_PWM1 9'h048
`define GMX_FN_PWM2 9'h049
`define GMX_FN_SPDIF 9'h04c
`define GMX_FN_SPK_SHORT 9'h0b6
`define GMX_FN_SPK_SHDN 9'h0e0
`define GMX_FN_TEMP_SHDN 9'h0e1
`define GMX_FN_TEMP_WARN 9'h0e2
`define GMX_FN_TMR1 9'h140
`define GMX_FN_TMR4 9'h143
`define GMX_FN_EVL1 9'h150
`define GMX_FN_EVL4 9'h153

// Source bus bit positions
`define GMX_SRC_INTERRUPT_REQUEST_ONE 5'h00
`define GMX_SRC_INTERRUPT_REQUEST_TWO 5'h01
`define GMX_SRC_FLL_CLK 5'h02
`define GMX_SRC_FLL_LOCK 5'h03
`define GMX_SRC_DIVIDED_SYSTEM_CLOCK_OUT 5'h04
`define GMX_SRC_PWM1 5'h05
`define GMX_SRC_PWM2 5'h06
`define GMX_SRC_SPDIF 5'h07
`define GMX_SRC_SPK_SHORT 5'h08
`define GMX_SRC_SPK_SHDN 5'h09
`define GMX_SRC_TEMP_SHDN 5'h0a
`define GMX_SRC_TEMP_WARN 5'h0b
`define GMX_SRC_TMR1 5'h0c
`define GMX_SRC_EVL1 5'h10
`define GMX_SRC_W 20

// Register byte offsets
`define GMX_OFF_CTRL1 8'h00
`define GMX_OFF_CTRL16 8'h3c
`define GMX_OFF_LEVEL 8'h40
`define GMX_OFF_DRIVE 8'h44

// Control word fields
`define GMX_FN_LSB 0
`define GMX_FN_MSB 8
`define GMX_DIR_BIT 15
`define GMX_ODC_BIT 16

// Reset values
`define GMX_RST_FN 9'h001
`define GMX_RST_DIR 1'b1
`define GMX_RST_ODC 1'b0
`define GMX_RST_LVL 16'h0000

// Fixed alternate-function pin table, bit i is pin i+1
`define GMX_ALT_OUT_MASK 16'h8a31
`define GMX_ALT_IO_MASK 16'h554a
`define GMX_ALT_IN_MASK 16'h2084
`define GMX_ALT_OD_MASK 16'h8040

// AXI responses
`define GMX_RESP_OKAY 2'b00
`define GMX_RESP_SLVERR 2'b10

`endif

//--- common/gmx_pkg.sv
`include "gmx_params.svh"

package gmx_pkg;

    typedef enum logic [2:0] {
        GMX_K_ALT,
        GMX_K_GPIO,
        GMX_K_DSP,
        GMX_K_SRC,
        GMX_K_RSVD
    } gmx_kind_t;

    typedef struct packed {
        gmx_kind_t kind;
        logic [4:0] idx;
    } gmx_sel_t;

    typedef logic [8:0] gmx_fn_t;

    function automatic gmx_sel_t gmx_decode(input gmx_fn_t code);
        gmx_sel_t s;
        s.kind = GMX_K_SRC;
        s.idx = 5'h00;
        if (code == `GMX_FN_ALT) begin
            s.kind = GMX_K_ALT;
        end else if (code == `GMX_FN_GPIO) begin
            s.kind = GMX_K_GPIO;
        end else if (code == `GMX_FN_DSP) begin
            s.kind = GMX_K_DSP;
        end else if (code == `GMX_FN_INTERRUPT_REQUEST_ONE) begin
            s.idx = `GMX_SRC_INTERRUPT_REQUEST_ONE;
        end else if (code == `GMX_FN_INTERRUPT_REQUEST_TWO) begin
            s.idx = `GMX_SRC_INTERRUPT_REQUEST_TWO;
        end else if (code == `GMX_FN_FLL_CLK) begin
            s.idx = `GMX_SRC_FLL_CLK;
        end else if (code == `GMX_FN_FLL_LOCK) begin
            s.idx = `GMX_SRC_FLL_LOCK;
        end else if (code == `GMX_FN_DIVIDED_SYSTEM_CLOCK_OUT) begin
            s.idx = `GMX_SRC_DIVIDED_SYSTEM_CLOCK_OUT;
        end else if (code == `GMX_FN_PWM1) begin
            s.idx = `GMX_SRC_PWM1;
        end else if (code == `GMX_FN_PWM2) begin
            s.idx = `GMX_SRC_PWM2;
        end else if (code == `GMX_FN_SPDIF) begin
            s.idx = `GMX_SRC_SPDIF;
        end else if (code == `GMX_FN_SPK_SHORT) begin
            s.idx = `GMX_SRC_SPK_SHORT;
        end else if (code == `GMX_FN_SPK_SHDN) begin
            s.idx = `GMX_SRC_SPK_SHDN;
        end else if (code == `GMX_FN_TEMP_SHDN) begin
            s.idx = `GMX_SRC_TEMP_SHDN;
        end else if (code == `GMX_FN_TEMP_WARN) begin
            s.idx = `GMX_SRC_TEMP_WARN;
        end else if (code >= `GMX_FN_TMR1 && code <= `GMX_FN_TMR4) begin
            s.idx = `GMX_SRC_TMR1 + 5'(code[1:0]);
        end else if (code >= `GMX_FN_EVL1 && code <= `GMX_FN_EVL4) begin
            s.idx = `GMX_SRC_EVL1 + 5'(code[1:0]);
        end else begin
            s.kind = GMX_K_RSVD;
        end
        return s;
    endfunction : gmx_decode

endpackage : gmx_pkg

//--- rtl/gmx_pin_cell.sv
`timescale 1ns/1ps
`default_nettype none

`include "gmx_params.svh"

module gmx_pin_cell #(
    parameter int PIN = 0
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire gmx_pkg::gmx_fn_t fn,
    input wire logic dir,
    input wire logic odc,
    input wire logic lvl,
    input wire logic alt_o,
    input wire logic alt_oe,
    input wire logic dsp_o,
    input wire logic dsp_oe,
    input wire logic [`GMX_SRC_W-1:0] src,
    output logic pin_o,
    output logic pin_oe
);
    import gmx_pkg::*;

    gmx_sel_t sel;
    logic val;
    logic en;
    logic od;

    // Table held as constants so a pin's own bit can be selected
    localparam logic [15:0] ALT_OUT = `GMX_ALT_OUT_MASK;
    localparam logic [15:0] ALT_IO = `GMX_ALT_IO_MASK;
    localparam logic [15:0] ALT_OD = `GMX_ALT_OD_MASK;

    if (PIN < 0 || PIN > 15) begin : g_bad_pin
        $error("gmx_pin_cell: PIN out of range");
    end

    always_comb begin
        sel = gmx_decode(fn);
        val = 1'b0;
        en = 1'b0;
        od = odc;
        unique case (sel.kind)
            GMX_K_ALT: begin
                // Only this pin's own alternate is wired in
                val = alt_o;
                en = ALT_OUT[PIN] |
                     (ALT_IO[PIN] & alt_oe);
                od = ALT_OD[PIN];
            end
            GMX_K_GPIO: begin
                val = lvl;
                en = ~dir;
            end
            GMX_K_DSP: begin
                val = dsp_o;
                en = dsp_oe;
            end
            GMX_K_SRC: begin
                val = src[sel.idx];
                en = ~dir;
            end
            GMX_K_RSVD: begin
                val = 1'b0;
                en = 1'b0;
            end
        endcase
    end

    // Open drain only ever pulls low
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_o <= 1'b0;
            pin_oe <= 1'b0;
        end else begin
            pin_o <= od ? 1'b0 : val;
            pin_oe <= en & (~od | ~val);
        end
    end

endmodule : gmx_pin_cell

`default_nettype wire

//--- rtl/gmx_mux.sv
`timescale 1ns/1ps
`default_nettype none

`include "gmx_params.svh"

module gmx_mux #(
    parameter int ADDR_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pins
    input wire logic [15:0] pin_i,
    output logic [15:0] pin_o,
    output logic [15:0] pin_oe,
    // Alternate functions, bit i belongs to pin i+1
    input wire logic [15:0] alt_o,
    input wire logic [15:0] alt_oe,
    output logic [15:0] alt_in,
    // DSP path
    input wire logic [15:0] dsp_o,
    input wire logic [15:0] dsp_oe,
    output logic [15:0] dsp_in,
    // Logic input level for button detect
    output logic [15:0] gpio_in_level,
    // Internal status and clock sources
    input wire logic interrupt_request_one,
    input wire logic interrupt_request_two,
    input wire logic fll_one_clock,
    input wire logic fll_one_lock,
    input wire logic divided_system_clock_out,
    input wire logic [1:0] pwm_out,
    input wire logic spdif_out,
    input wire logic left_speaker_short,
    input wire logic speaker_shutdown_done,
    input wire logic temp_above_shutdown,
    input wire logic temp_above_warning,
    input wire logic [3:0] timer_pulse,
    input wire logic [3:0] event_fifo_not_empty
);
    import gmx_pkg::*;

    // The map needs seven address bits; the top bits are range-checked
    if (ADDR_W < 7 || ADDR_W > 32) begin : g_bad_addr_w
        $error("gmx_mux: ADDR_W must be 7 to 32");
    end

    ////////////////////////////////////////////////////////////////////////

    gmx_fn_t fn_q [16];
    logic [15:0] dir_q;
    logic [15:0] odc_q;
    logic [15:0] lvl_q;
    logic [15:0] pin_in_q;
    logic [`GMX_SRC_W-1:0] src;

    logic wr_go;
    logic rd_go;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;
    logic [7:0] waddr;
    logic [7:0] raddr;
    logic ctrl_wr;
    logic [3:0] ctrl_idx;
    logic lvl_wr;
    logic rd_ctrl;
    logic [3:0] rd_idx;
    logic [1:0] bresp_d;
    logic [1:0] rresp_d;
    logic [31:0] rdata_d;
    logic [15:0] level_view;

    function automatic logic addr_is_ctrl(input logic [7:0] a);
        return a[1:0] == 2'b00 && a >= `GMX_OFF_CTRL1 &&
            a <= `GMX_OFF_CTRL16;
    endfunction : addr_is_ctrl

    function automatic logic addr_ok(input logic [7:0] a);
        return addr_is_ctrl(a) || a == `GMX_OFF_LEVEL ||
            a == `GMX_OFF_DRIVE;
    endfunction : addr_ok

    function automatic logic [3:0] ctrl_index(input logic [7:0] a);
        return a[5:2];
    endfunction : ctrl_index

    // Byte lanes of the level word; upper lanes carry nothing
    function automatic logic [15:0] merge_lanes(input logic [15:0] old,
            input logic [15:0] wd, input logic [1:0] be);
        logic [15:0] m;
        m = old;
        if (be[0]) begin
            m[7:0] = wd[7:0];
        end
        if (be[1]) begin
            m[15:8] = wd[15:8];
        end
        return m;
    endfunction : merge_lanes

    // Bits above the map must be zero, or the access is unmapped
    function automatic logic [7:0] low_addr(input logic [ADDR_W-1:0] a);
        logic [31:0] w;
        w = 32'(a);
        return (w[31:8] == 24'h000000) ? w[7:0] : 8'hff;
    endfunction : low_addr

    assign waddr = low_addr(s_axi_awaddr);
    assign raddr = low_addr(s_axi_araddr);

    ////////////////////////////////////////////////////////////////////////
    // Write channel: address and data taken together in one beat

    assign wr_go = s_axi_awvalid & s_axi_wvalid & ~bvalid_q;
    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    // Unmapped writes answer an error and change nothing
    assign bresp_d = addr_ok(waddr) ? `GMX_RESP_OKAY : `GMX_RESP_SLVERR;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= `GMX_RESP_OKAY;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q <= bresp_d;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control and level registers

    // Decoded once so every field register sees the same strobe
    assign ctrl_wr = wr_go && addr_is_ctrl(waddr);
    assign ctrl_idx = ctrl_index(waddr);
    assign lvl_wr = wr_go && waddr == `GMX_OFF_LEVEL;

    // Software owns codes and direction; hardware does not check them
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < 16; i++) begin
                fn_q[i] <= `GMX_RST_FN;
            end
        end else if (ctrl_wr) begin
            if (s_axi_wstrb[0]) begin
                fn_q[ctrl_idx][7:0] <= s_axi_wdata[7:0];
            end
            if (s_axi_wstrb[1]) begin
                fn_q[ctrl_idx][8] <= s_axi_wdata[`GMX_FN_MSB];
            end
        end
    end

    // Direction shares byte lane 1 with the top code bit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dir_q <= {16{`GMX_RST_DIR}};
        end else if (ctrl_wr && s_axi_wstrb[1]) begin
            dir_q[ctrl_idx] <= s_axi_wdata[`GMX_DIR_BIT];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            odc_q <= {16{`GMX_RST_ODC}};
        end else if (ctrl_wr && s_axi_wstrb[2]) begin
            odc_q[ctrl_idx] <= s_axi_wdata[`GMX_ODC_BIT];
        end
    end

    // Lanes 0 and 1 carry pins 1-8 and 9-16
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lvl_q <= `GMX_RST_LVL;
        end else if (lvl_wr) begin
            lvl_q <= merge_lanes(lvl_q, s_axi_wdata[15:0], s_axi_wstrb[1:0]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read channel

    assign rd_go = s_axi_arvalid & ~rvalid_q;
    assign s_axi_arready = rd_go;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    function automatic logic [31:0] ctrl_word(input logic [3:0] i,
            input gmx_fn_t f, input logic [15:0] d, input logic [15:0] o);
        logic [31:0] w;
        w = 32'h00000000;
        w[`GMX_FN_MSB:`GMX_FN_LSB] = f;
        w[`GMX_DIR_BIT] = d[i];
        w[`GMX_ODC_BIT] = o[i];
        return w;
    endfunction : ctrl_word

    assign rd_ctrl = addr_is_ctrl(raddr);
    assign rd_idx = ctrl_index(raddr);
    // Driven pins read the stored level, others the pin
    assign level_view = (lvl_q & pin_oe) | (pin_in_q & ~pin_oe);

    // Next read answer, worked out from the address and the current register and pin state
    always_comb begin
        rdata_d = 32'h00000000;
        rresp_d = `GMX_RESP_OKAY;
        if (rd_ctrl) begin
            rdata_d = ctrl_word(rd_idx, fn_q[rd_idx], dir_q, odc_q);
        end else if (raddr == `GMX_OFF_LEVEL) begin
            rdata_d = {16'h0000, level_view};
        end else if (raddr == `GMX_OFF_DRIVE) begin
            rdata_d = {16'h0000, pin_oe};
        end else begin
            rresp_d = `GMX_RESP_SLVERR;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rresp_q <= `GMX_RESP_OKAY;
            rdata_q <= 32'h00000000;
        end else if (rd_go) begin
            rvalid_q <= 1'b1;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin inputs fan out to every consumer from one register

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_in_q <= 16'h0000;
        end else begin
            pin_in_q <= pin_i;
        end
    end

    assign alt_in = pin_in_q;
    assign dsp_in = pin_in_q;
    assign gpio_in_level = pin_in_q;

    ////////////////////////////////////////////////////////////////////////
    // Source bus; order matches the source index defines

    always_comb begin
        src = '0;
        src[`GMX_SRC_INTERRUPT_REQUEST_ONE] = interrupt_request_one;
        src[`GMX_SRC_INTERRUPT_REQUEST_TWO] = interrupt_request_two;
        src[`GMX_SRC_FLL_CLK] = fll_one_clock;
        src[`GMX_SRC_FLL_LOCK] = fll_one_lock;
        src[`GMX_SRC_DIVIDED_SYSTEM_CLOCK_OUT] = divided_system_clock_out;
        src[`GMX_SRC_PWM1] = pwm_out[0];
        src[`GMX_SRC_PWM2] = pwm_out[1];
        src[`GMX_SRC_SPDIF] = spdif_out;
        src[`GMX_SRC_SPK_SHORT] = left_speaker_short;
        src[`GMX_SRC_SPK_SHDN] = speaker_shutdown_done;
        src[`GMX_SRC_TEMP_SHDN] = temp_above_shutdown;
        src[`GMX_SRC_TEMP_WARN] = temp_above_warning;
        for (int t = 0; t < 4; t++) begin
            src[`GMX_SRC_TMR1 + 5'(t)] = timer_pulse[t];
            src[`GMX_SRC_EVL1 + 5'(t)] = event_fifo_not_empty[t];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // One cell per pin. Clocks pass through a flop at 200 MHz, so
    // forwarded clocks carry up to one cycle of jitter; keep them slow.

    for (genvar p = 0; p < 16; p++) begin : g_pin
        gmx_pin_cell #(
            .PIN(p)
        ) u_cell (
            .aclk(aclk),
            .aresetn(aresetn),
            .fn(fn_q[p]),
            .dir(dir_q[p]),
            .odc(odc_q[p]),
            .lvl(lvl_q[p]),
            .alt_o(alt_o[p]),
            .alt_oe(alt_oe[p]),
            .dsp_o(dsp_o[p]),
            .dsp_oe(dsp_oe[p]),
            .src(src),
            .pin_o(pin_o[p]),
            .pin_oe(pin_oe[p])
        );
    end

endmodule : gmx_mux

`default_nettype wire

//--- sim/gmx_mux_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module gmx_mux_asserts (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [15:0] pin_i,
    input wire logic [15:0] pin_oe,
    input wire logic [15:0] alt_in,
    input wire logic [15:0] dsp_in,
    input wire logic [15:0] gpio_in_level
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_wtake;
        s_axi_awvalid && s_axi_wvalid && s_axi_awready;
    endsequence
    sequence s_rtake;
        s_axi_arvalid && s_axi_arready;
    endsequence

    ////////////////////////////////////////////////////////////////////////
    a_write_answer: assert property (s_wtake |=> s_axi_bvalid)
        else $error("write response missing");
    a_write_cycle: assert property (
        s_wtake ##1 (s_axi_bvalid && s_axi_bready) |=> !s_axi_bvalid)
        else $error("write response not retired");
    a_bvalid_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=>
            s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_write_single: assert property (
        (s_axi_awready == s_axi_wready) && (s_axi_bvalid -> !s_axi_awready))
        else $error("write accepted out of turn");
    a_read_answer: assert property (s_rtake |=> s_axi_rvalid)
        else $error("read response missing");
    a_rvalid_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
            $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read response dropped early");
    // Input path is one register stage behind the pins
    a_input_sample: assert property (
        $past(aresetn) |-> alt_in == $past(pin_i))
        else $error("pin input not sampled");
    a_input_copies: assert property (
        dsp_in == alt_in && gpio_in_level == alt_in)
        else $error("input copies disagree");
    a_oe_reset: assert property ($rose(aresetn) |-> pin_oe == 16'h0000)
        else $error("pins driven after reset");
endmodule : gmx_mux_asserts

bind gmx_mux gmx_mux_asserts i_gmx_mux_asserts (.aclk, .aresetn,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .pin_i, .pin_oe, .alt_in, .dsp_in, .gpio_in_level);

`default_nettype wire

//--- sim/gmx_pin_world.sv
`timescale 1ns/1ps
`default_nettype none

module gmx_pin_world (
    input wire logic aclk,
    input wire logic [15:0] pin_o,
    input wire logic [15:0] pin_oe,
    input wire logic [15:0] ext_o,
    input wire logic [15:0] ext_oe,
    output logic [15:0] pin_i
);
    // I2C lines carry board pull-ups
    localparam logic [15:0] PULL_UP = 16'h8040;
    logic [15:0] pat_q = 16'h5a5a;

    // Floating lines wander so a stale value never looks valid
    always_ff @(posedge aclk) begin
        pat_q <= ~pat_q;
    end

    // Device wins a clash; contention is not modelled
    always_comb begin
        for (int b = 0; b < 16; b++) begin
            if (pin_oe[b] === 1'b1) pin_i[b] = pin_o[b];
            else if (ext_oe[b] === 1'b1) pin_i[b] = ext_o[b];
            else if (PULL_UP[b]) pin_i[b] = 1'b1;
            else pin_i[b] = pat_q[b];
        end
    end
endmodule : gmx_pin_world

`default_nettype wire

//--- sim/gmx_mux_bench.sv
`timescale 1ns/1ps
`default_nettype none

module gmx_mux_bench;
    // Bit i is pin i+1
    localparam logic [15:0] ALT_OUT = 16'h8a31;
    localparam logic [15:0] ALT_IO = 16'h554a;
    localparam logic [15:0] ALT_OD = 16'h8040;
    // Index k-3 of the source vector for k in 3..22; last two reserved
    localparam logic [8:0] CODES [25] = '{9'h000, 9'h001, 9'h002, 9'h003,
        9'h004, 9'h010, 9'h018, 9'h040, 9'h048, 9'h049, 9'h04c, 9'h0b6,
        9'h0e0, 9'h0e1, 9'h0e2, 9'h140, 9'h141, 9'h142, 9'h143, 9'h150,
        9'h151, 9'h152, 9'h153, 9'h005, 9'h1ff};

    logic aclk = 1'b0;
    logic aresetn;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [15:0] pin_i, pin_o, pin_oe, alt_o, alt_oe, alt_in;
    logic [15:0] dsp_o, dsp_oe, dsp_in, gpio_in_level, ext_o, ext_oe, lv;
    logic [19:0] s;
    int seed, miscompares, comparisons, cycles;
    int p, k;
    logic dir, odc;
    logic [1:0] r, e;
    logic [31:0] d, cw;

    always #2.5 aclk = ~aclk;

    gmx_mux i_gmx_mux (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .pin_i, .pin_o, .pin_oe, .alt_o,
        .alt_oe, .alt_in, .dsp_o, .dsp_oe, .dsp_in, .gpio_in_level,
        .interrupt_request_one(s[0]), .interrupt_request_two(s[1]),
        .fll_one_clock(s[2]), .fll_one_lock(s[3]),
        .divided_system_clock_out(s[4]), .pwm_out(s[6:5]),
        .spdif_out(s[7]), .left_speaker_short(s[8]),
        .speaker_shutdown_done(s[9]), .temp_above_shutdown(s[10]),
        .temp_above_warning(s[11]), .timer_pulse(s[15:12]),
        .event_fifo_not_empty(s[19:16]));

    gmx_pin_world i_gmx_pin_world (.aclk, .pin_o, .pin_oe, .ext_o,
        .ext_oe, .pin_i);

    ////////////////////////////////////////////////////////////////////////
    task automatic conclude;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : conclude

    task automatic chk(input string n, input logic [31:0] x,
                       input logic [31:0] g);
        comparisons++;
        if (g !== x) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", n, x, g);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] v,
                      output logic [1:0] resp);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (s_axi_awready !== 1'b1);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        while (s_axi_bvalid !== 1'b1) @(posedge aclk);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] v,
                      output logic [1:0] resp);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1) @(posedge aclk);
        v = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd

    // Returns {drive enable, driven value} for pin bit q
    function automatic logic [1:0] expect_pin(int q, int c, logic dr,
                                              logic od_cfg);
        logic v;
        logic oe;
        logic od;
        v = 1'b0;
        oe = ~dr;
        od = od_cfg;
        if (c == 0) begin
            v = alt_o[q];
            od = ALT_OD[q];
            oe = ALT_OUT[q] | (ALT_IO[q] & alt_oe[q]);
        end else if (c == 1) begin
            v = lv[q];
        end else if (c == 2) begin
            v = dsp_o[q];
            oe = dsp_oe[q];
        end else if (c < 23) begin
            v = s[c-3];
        end else begin
            oe = 1'b0;
        end
        return od ? {oe & ~v, 1'b0} : {oe, v};
    endfunction : expect_pin

    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            conclude;
        end
    end

    initial begin
        seed = 32'hd527bb15;
        {miscompares, comparisons} = '0;
        aresetn = 1'b0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
        {alt_o, alt_oe, dsp_o, dsp_oe, ext_o, ext_oe, lv, s} = '0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        for (int n = 0; n < 16; n++) begin
            rd(8'(4 * n), d, r);
            chk("ctrl reset", 32'h8001, d & 32'h181ff);
        end
        rd(8'h44, d, r);
        chk("drive reset", 32'h0, d);
        rd(8'h48, d, r);
        chk("unmapped rresp", 32'h2, r);
        chk("unmapped rdata", 32'h0, d);
        wr(8'h02, 32'h0, r);
        chk("unaligned bresp", 32'h2, r);
        for (int i = 0; i < 150; i++) begin
            p = $unsigned($random(seed)) % 16;
            k = i < 25 ? i : $unsigned($random(seed)) % 25;
            odc = 1'($random(seed));
            // Sourced outputs get an output direction
            dir = (k > 2 && k < 23) ? 1'b0 : 1'($random(seed));
            cw = {15'h0, odc, dir, 6'h0, CODES[k]};
            wr(8'(4 * p), cw, r);
            lv = 16'($random(seed));
            wr(8'h40, {16'h0, lv}, r);
            @(posedge aclk);
            s <= 20'($random(seed));
            alt_o <= 16'($random(seed));
            alt_oe <= 16'($random(seed));
            dsp_o <= 16'($random(seed));
            dsp_oe <= 16'($random(seed));
            ext_o <= 16'($random(seed));
            ext_oe <= 16'($random(seed));
            repeat (3) @(posedge aclk);
            #1;
            e = expect_pin(p, k, dir, odc);
            chk("pin_oe", e[1], pin_oe[p]);
            if (e[1] || k > 22) chk("pin_o", e[0], pin_o[p]);
            if (k == 1 && dir && ext_oe[p]) chk("level in", ext_o[p], gpio_in_level[p]);
            rd(8'(4 * p), d, r);
            chk("ctrl readback", cw, d & 32'h181ff);
            rd(8'h44, d, r);
            chk("drive bit", e[1], d[p]);
            rd(8'h40, d, r);
            if (e[1] || ext_oe[p]) begin
                chk("level", e[1] ? lv[p] : ext_o[p], d[p]);
            end
        end
        conclude;
    end
endmodule : gmx_mux_bench

`default_nettype wire
